// file: design/nvm_cfg.svh
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// Control register: index as printed, byte address four times that
`define CTRL_INDEX 32'h0000_0007
`define CTRL_ADDR (`CTRL_INDEX * 32'h0000_0004)
`define CTRL_RESET 8'h00

// Control register bit positions
`define BIT_IRQ_EN 7
`define BIT_ASLEEP 6
`define BIT_OTP_LAT 5
`define BIT_OTP_PGM 4
`define BIT_CLK_OUT 3
`define BIT_NV_ERASE 2
`define BIT_NV_LAT 1
`define BIT_NV_PUMP 0

// One-time-programmable array decode
`define OTP_MAIN_LO 16'h0400
`define OTP_MAIN_HI 16'h7dff
`define OTP_VECT_LO 16'h7ff0
`define OTP_OPTION 16'h7fde

// Byte-erasable array decode
`define NV_LO 16'h0100
`define NV_HI 16'h01ff

// Value returned where the array content is not available
`define BLANK_BYTE 8'h00

`endif

// file: design/nvm_pkg.sv
package nvm_pkg;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_in_type;

   typedef struct packed {
      logic hreadyout;
      logic [31:0] hrdata;
      logic hresp;
   } ahb_out_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mem_req_type;

   typedef struct packed {
      logic active;
      logic [11:0] group;
      logic [15:0] mask;
      logic [15:0][7:0] data;
   } otp_prog_type;

   typedef struct packed {
      logic pump_on;
      logic erase;
      logic [15:0] addr;
      logic [7:0] data;
   } nv_prog_type;

   typedef enum logic [1:0] {
      OTP_READ = 2'b00,
      OTP_LOAD = 2'b10,
      OTP_PROGRAM = 2'b11
   } otp_mode_type;

   typedef enum logic [2:0] {
      NV_READ = 3'b000,
      NV_LOAD = 3'b010,
      NV_PROGRAM = 3'b011,
      NV_ERASE_LOAD = 3'b110,
      NV_ERASE = 3'b111
   } nv_mode_type;

   typedef struct packed {
      logic irq_en;
      logic asleep;
      logic otp_lat;
      logic otp_pgm;
      logic clk_out_en;
      logic nv_erase;
      logic nv_lat;
      logic nv_pump;
      logic [11:0] otp_group;
      logic [15:0] otp_mask;
      logic [15:0][7:0] otp_data;
      logic nv_loaded;
      logic [15:0] nv_addr;
      logic [7:0] nv_data;
      logic wr_pend;
      logic hreadyout;
      logic [31:0] hrdata;
      logic [7:0] mem_rdata;
      logic [1:0] sleep_sync;
      logic [1:0] opt_sync;
      otp_mode_type otp_mode;
      nv_mode_type nv_mode;
   } state_type;

endpackage

// file: design/nvm_program_control.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "nvm_cfg.svh"

// Function
// - Latch enable clear gives plain array reads; clearing it clears program enable.
// - With latch enable set, array and vector reads return blank, fetches blocked.
// - Stop mode forces the array back to read mode.
// - Stop and reset clear latch enable and with it program enable.
// - Unprogrammed or unavailable bytes read as zero.
// - Programming only adds one bits; repeat programming cannot clear bits.
// - Latch set, program clear: array writes latch group address and sixteen bytes.
// - Program enable sets only after latch and one byte; software clears it only by clearing latch enable.
// - Mode decodes from latch and program bits; 0,1 never occurs.
// - Decode main block, every address from the vector base 7ff0 upward, and the option byte.
// - Wired-OR enable works only with factory option set; reset clears it.
// - Asleep flag follows the CAN controller sleep state at bit 6.
// - Erase select chooses erase or program, frozen once address latched.
// - Latch set, pump clear: writes latch address and data; latch clear keeps the last values.
// - Stop and reset clear byte array latch, erase select and pump.
// - Pump bit drives charge pump, needs latched data, clears only with latch.
// - Byte array mode decodes from erase select, latch and pump bits.
module nvm_program_control (
   input wire logic ref_clk,
   input wire logic rst,
   input nvm_pkg::ahb_in_type ahb_i,
   output nvm_pkg::ahb_out_type ahb_o,
   input nvm_pkg::mem_req_type mem_i,
   input wire logic [7:0] otp_array_rdata,
   input wire logic [7:0] nv_array_rdata,
   input wire logic stop_mode,
   input wire logic can_sleep,
   input wire logic wired_or_irq_option,
   output logic [7:0] mem_rdata,
   output logic rom_fetch_blocked,
   output nvm_pkg::otp_prog_type otp_prog,
   output nvm_pkg::nv_prog_type nv_prog,
   output logic wired_or_irq_enable,
   output logic bus_clock_out_enable,
   output logic can_asleep_flag,
   output nvm_pkg::otp_mode_type otp_mode,
   output nvm_pkg::nv_mode_type nv_mode
);
   import nvm_pkg::*;

   state_type q;
   state_type d;
   logic take;
   logic hit;
   logic opt;
   logic [7:0] wd;
   logic in_otp;
   logic in_nv;
   logic [7:0] ctrl_rd;

   // Address decode of the two arrays
   assign in_otp = (mem_i.addr >= `OTP_MAIN_LO && mem_i.addr <= `OTP_MAIN_HI) ||
                   mem_i.addr >= `OTP_VECT_LO || mem_i.addr == `OTP_OPTION;
   assign in_nv = mem_i.addr >= `NV_LO && mem_i.addr <= `NV_HI;
   assign take = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
   assign hit = ahb_i.haddr == `CTRL_ADDR;
   assign opt = q.opt_sync[1];
   assign wd = ahb_i.hwdata[7:0];

   // Next state
   always_comb begin
      d = q;
      d.hreadyout = 1'b1;
      d.sleep_sync = {q.sleep_sync[0], can_sleep};
      d.opt_sync = {q.opt_sync[0], wired_or_irq_option};
      d.asleep = q.sleep_sync[1];

      // Register write in the data phase
      if (q.wr_pend) begin
         d.clk_out_en = wd[`BIT_CLK_OUT];
         d.irq_en = wd[`BIT_IRQ_EN] & opt;
         d.otp_lat = wd[`BIT_OTP_LAT];
         if (wd[`BIT_OTP_PGM] && wd[`BIT_OTP_LAT] && q.otp_lat && (|q.otp_mask)) begin
            d.otp_pgm = 1'b1;
         end
         d.nv_lat = wd[`BIT_NV_LAT];
         if (q.nv_lat && !q.nv_loaded) begin
            d.nv_erase = wd[`BIT_NV_ERASE];
         end
         if (wd[`BIT_NV_PUMP] && wd[`BIT_NV_LAT] && q.nv_lat && q.nv_loaded) begin
            d.nv_pump = 1'b1;
         end
      end

      // Array writes latch address and data only in load mode
      if (mem_i.valid && mem_i.write && in_otp && q.otp_lat && !q.otp_pgm) begin
         if (!(|q.otp_mask) || q.otp_group == mem_i.addr[15:4]) begin
            d.otp_group = mem_i.addr[15:4];
            d.otp_mask[mem_i.addr[3:0]] = 1'b1;
            d.otp_data[mem_i.addr[3:0]] = mem_i.wdata;
         end
      end
      if (mem_i.valid && mem_i.write && in_nv && q.nv_lat && !q.nv_pump) begin
         d.nv_addr = mem_i.addr;
         d.nv_data = mem_i.wdata;
         d.nv_loaded = 1'b1;
      end

      // Forced clears, stop mode before the latch clears
      if (!opt) begin
         d.irq_en = 1'b0;
      end
      if (stop_mode) begin
         d.otp_lat = 1'b0;
         d.nv_lat = 1'b0;
      end
      if (!d.otp_lat) begin
         d.otp_pgm = 1'b0;
         d.otp_mask = 16'h0000;
      end
      if (!d.nv_lat) begin
         d.nv_erase = 1'b0;
         d.nv_pump = 1'b0;
         d.nv_loaded = 1'b0;
      end
      d.otp_mode = otp_mode_type'({d.otp_lat, d.otp_pgm});
      d.nv_mode = nv_mode_type'({d.nv_erase, d.nv_lat, d.nv_pump});

      // Register read sees a write finishing in the same cycle
      ctrl_rd = {d.irq_en, d.asleep, d.otp_lat, d.otp_pgm, d.clk_out_en, d.nv_erase, d.nv_lat, d.nv_pump};
      d.wr_pend = take && ahb_i.hwrite && hit;
      d.hrdata = (take && !ahb_i.hwrite && hit) ? {24'h00_0000, ctrl_rd} : 32'h0000_0000;

      // Array read path
      if (in_otp) begin
         d.mem_rdata = q.otp_lat ? `BLANK_BYTE : otp_array_rdata;
      end else if (in_nv) begin
         d.mem_rdata = q.nv_lat ? `BLANK_BYTE : nv_array_rdata;
      end else begin
         d.mem_rdata = `BLANK_BYTE;
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs from flops, hresp tied to zero
   assign ahb_o.hreadyout = q.hreadyout;
   assign ahb_o.hrdata = q.hrdata;
   assign ahb_o.hresp = 1'b0;
   assign mem_rdata = q.mem_rdata;
   assign rom_fetch_blocked = q.otp_lat;
   assign otp_prog.active = q.otp_pgm;
   assign otp_prog.group = q.otp_group;
   assign otp_prog.mask = q.otp_mask;
   assign otp_prog.data = q.otp_data;
   assign nv_prog.pump_on = q.nv_pump;
   assign nv_prog.erase = q.nv_erase;
   assign nv_prog.addr = q.nv_addr;
   assign nv_prog.data = q.nv_data;
   assign wired_or_irq_enable = q.irq_en;
   assign bus_clock_out_enable = q.clk_out_en;
   assign can_asleep_flag = q.asleep;
   assign otp_mode = q.otp_mode;
   assign nv_mode = q.nv_mode;

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // One-time array control bits
   a_pgm_needs_lat: assert property (q.otp_pgm |-> q.otp_lat)
      else $error("program enable set without latch enable");

   a_pgm_no_sw_clear: assert property (q.otp_pgm && q.otp_lat && !stop_mode && !(q.wr_pend && !wd[`BIT_OTP_LAT])
      |=> q.otp_pgm)
      else $error("program enable cleared without latch clear");

   a_pgm_needs_byte: assert property ((q.otp_mask == 16'h0000) && !q.otp_pgm
      |=> !q.otp_pgm)
      else $error("program enable set before any byte latched");

   a_pgm_gate_lat: assert property (!q.otp_lat
      |=> !q.otp_pgm)
      else $error("program enable set while latch was clear");

   a_otp_lat_clear: assert property (!q.otp_lat
      |-> !q.otp_pgm && q.otp_mask == 16'h0000)
      else $error("latch clear left program state behind");

   a_otp_lat_write: assert property (q.wr_pend && !wd[`BIT_OTP_LAT]
      |=> !q.otp_lat && !q.otp_pgm)
      else $error("latch write of zero did not clear program enable");

   a_otp_mode_code: assert property (1'b1
      |-> q.otp_mode == otp_mode_type'({q.otp_lat, q.otp_pgm}))
      else $error("one-time mode does not match control bits");

   a_otp_mode_legal: assert property (1'b1
      |-> q.otp_mode != otp_mode_type'(2'b01))
      else $error("one-time mode shows program without latch");

   a_fetch_block: assert property (1'b1
      |-> rom_fetch_blocked == q.otp_lat)
      else $error("fetch block does not follow latch enable");

   // Stop mode and latch hold
   a_stop_clears: assert property (stop_mode |=> !q.otp_lat && !q.nv_lat && !q.nv_pump && !q.otp_pgm)
      else $error("stop mode did not clear latches");

   a_stop_read: assert property (stop_mode
      |=> q.otp_mode == OTP_READ && q.nv_mode == NV_READ)
      else $error("stop mode did not return to read mode");

   a_ctrl_hold: assert property (!q.wr_pend && !stop_mode
      |=> $stable(q.otp_lat) && $stable(q.nv_lat))
      else $error("latch enable changed without write or stop");

   // Interrupt enable and asleep flag
   a_wired_or_irq_enable_gated: assert property (!opt |=> !q.irq_en)
      else $error("wired-or enable set without option");

   a_irq_en_write: assert property (q.wr_pend && !wd[`BIT_IRQ_EN]
      |=> !q.irq_en)
      else $error("wired-or enable kept after write of zero");

   a_caf_follow: assert property ($rose(q.sleep_sync[1]) |=> q.asleep)
      else $error("asleep flag missed sleep entry");

   a_caf_drop: assert property ($fell(q.sleep_sync[1])
      |=> !q.asleep)
      else $error("asleep flag missed wake up");

   // Byte array control bits
   a_pump_needs_data: assert property ($rose(q.nv_pump) |-> $past(q.nv_loaded) && q.nv_lat)
      else $error("pump on before data latched");

   a_pump_gate: assert property (!q.nv_loaded && !q.nv_pump
      |=> !q.nv_pump)
      else $error("pump set without latched data");

   a_pump_needs_lat: assert property (q.nv_pump
      |-> q.nv_lat)
      else $error("pump on with latch clear");

   a_pump_sticky: assert property (q.nv_pump && !stop_mode && !(q.wr_pend && !wd[`BIT_NV_LAT])
      |=> q.nv_pump)
      else $error("pump cleared without latch clear");

   a_erase_frozen: assert property (q.nv_loaded && q.nv_lat ##1 q.nv_lat |-> $stable(q.nv_erase))
      else $error("erase select changed after address latched");

   a_erase_gate: assert property (!q.nv_lat
      |=> !q.nv_erase)
      else $error("erase select set while latch was clear");

   a_nv_idle_zero: assert property (!q.nv_lat |-> !q.nv_erase && !q.nv_pump)
      else $error("erase or pump set with latch clear");

   a_nv_lat_write: assert property (q.wr_pend && !wd[`BIT_NV_LAT]
      |=> !q.nv_lat && !q.nv_erase && !q.nv_pump)
      else $error("byte array latch clear left erase or pump set");

   a_nv_mode_code: assert property (1'b1
      |-> q.nv_mode == nv_mode_type'({q.nv_erase, q.nv_lat, q.nv_pump}))
      else $error("byte array mode does not match control bits");

   a_nv_mode_legal: assert property (1'b1
      |-> q.nv_mode inside {NV_READ, NV_LOAD, NV_PROGRAM, NV_ERASE_LOAD, NV_ERASE})
      else $error("byte array mode holds an unlisted code");

   // Array write latching
   a_otp_load_takes: assert property (mem_i.valid && mem_i.write && in_otp && q.otp_lat && !q.otp_pgm && !stop_mode
      && !(q.wr_pend && !wd[`BIT_OTP_LAT]) |=> (|q.otp_mask))
      else $error("one-time write in load mode not latched");

   a_otp_group_hold: assert property ((|q.otp_mask)
      |=> $stable(q.otp_group))
      else $error("latched group changed while bytes held");

   a_otp_pgm_freeze: assert property (q.otp_pgm
      |=> $stable(q.otp_data))
      else $error("latched bytes changed while programming");

   a_otp_other_group: assert property ((|q.otp_mask) && mem_i.valid && mem_i.write && mem_i.addr[15:4] != q.otp_group
      |=> $stable(q.otp_data))
      else $error("write outside the latched group was taken");

   a_otp_closed_hold: assert property (!q.otp_lat
      |=> $stable(q.otp_data))
      else $error("one-time bytes changed with latch clear");

   a_nv_closed_hold: assert property (!q.nv_lat
      |=> $stable(q.nv_addr) && $stable(q.nv_data))
      else $error("byte array latch changed with latch clear");

   a_nv_pump_hold: assert property (q.nv_pump
      |=> $stable(q.nv_addr) && $stable(q.nv_data))
      else $error("byte array latch changed while pumping");

   a_nv_load_takes: assert property (mem_i.valid && mem_i.write && in_nv && q.nv_lat && !q.nv_pump
      |=> q.nv_addr == $past(mem_i.addr) && q.nv_data == $past(mem_i.wdata))
      else $error("byte array write in load mode not latched");

   // Array read path
   a_blank_read: assert property (mem_i.valid && !mem_i.write && in_otp && q.otp_lat
      |=> mem_rdata == `BLANK_BYTE)
      else $error("array read not blank while latched");

   a_vector_blank: assert property (mem_i.valid && !mem_i.write && mem_i.addr >= `OTP_VECT_LO && q.otp_lat
      |=> mem_rdata == `BLANK_BYTE)
      else $error("vector read not blank while latched");

   a_otp_read_pass: assert property (mem_i.valid && !mem_i.write && in_otp && !q.otp_lat
      |=> mem_rdata == $past(otp_array_rdata))
      else $error("one-time array read not passed through");

   a_nv_read_pass: assert property (mem_i.valid && !mem_i.write && in_nv && !q.nv_lat
      |=> mem_rdata == $past(nv_array_rdata))
      else $error("byte array read not passed through");

   a_nv_blank: assert property (mem_i.valid && !mem_i.write && in_nv && q.nv_lat
      |=> mem_rdata == `BLANK_BYTE)
      else $error("byte array read not blank while latched");

   a_unmapped_zero: assert property (mem_i.valid && !in_otp && !in_nv
      |=> mem_rdata == `BLANK_BYTE)
      else $error("unmapped read not zero");

   // Main scenarios
   c_otp_program: cover property (q.otp_mode == OTP_LOAD ##[1:50] q.otp_mode == OTP_PROGRAM);
   c_nv_erase: cover property (q.nv_mode == NV_ERASE_LOAD ##[1:50] q.nv_mode == NV_ERASE);
   c_nv_program: cover property (q.nv_mode == NV_LOAD ##[1:50] q.nv_mode == NV_PROGRAM);
   c_stop_clear: cover property (q.otp_lat && stop_mode ##1 !q.otp_lat);
   c_asleep_set: cover property ($rose(q.asleep));

endmodule // nvm_program_control

// file: tb/tb.sv
`timescale 1ns/1ps
`include "nvm_cfg.svh"

module tb;
   import nvm_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic stop_mode = 1'b0;
   logic can_sleep = 1'b0;
   logic opt = 1'b0;
   ahb_in_type ahb_q = '0;
   ahb_in_type ahb_in;
   ahb_out_type ahb_o;
   mem_req_type mem_q = '0;
   otp_prog_type otp_prog;
   nv_prog_type nv_prog;
   otp_mode_type otp_mode;
   nv_mode_type nv_mode;
   logic [7:0] mem_rdata, mr;
   logic blk, irq_en, clk_oe, asleep, rdy_q;
   logic [31:0] rd_q, rv;
   logic [15:0] dec_a [6] = '{16'h0400, 16'h7dff, 16'h7fde, 16'h7ff0, 16'h7e00, 16'h03ff};
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   // Clock and hready loop-back
   initial forever #5 ref_clk = ~ref_clk;
   always_comb begin
      ahb_in = ahb_q;
      ahb_in.hready = ahb_o.hreadyout;
   end

   nvm_program_control dut_u (.ref_clk(ref_clk), .rst(rst), .ahb_i(ahb_in), .ahb_o(ahb_o),
      .mem_i(mem_q), .otp_array_rdata(8'h3c), .nv_array_rdata(8'h96), .stop_mode(stop_mode),
      .can_sleep(can_sleep), .wired_or_irq_option(opt), .mem_rdata(mem_rdata),
      .rom_fetch_blocked(blk), .otp_prog(otp_prog), .nv_prog(nv_prog), .wired_or_irq_enable(irq_en),
      .bus_clock_out_enable(clk_oe), .can_asleep_flag(asleep), .otp_mode(otp_mode), .nv_mode(nv_mode));

   // Edge samples of the answer and hang guard
   always @(posedge ref_clk) begin
      rdy_q <= ahb_o.hreadyout;
      rd_q <= ahb_o.hrdata;
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors = errors + 1;
         stop_test;
      end
   end

   task tick;
      @(posedge ref_clk);
      #1;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Single AHB transfer, address phase then data phase
   task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
      ahb_q.hsel <= 1'b1;
      ahb_q.haddr <= a;
      ahb_q.htrans <= 2'b10;
      ahb_q.hwrite <= wr;
      ahb_q.hsize <= 3'b010;
      do tick; while (rdy_q !== 1'b1);
      ahb_q.hsel <= 1'b0;
      ahb_q.htrans <= 2'b00;
      ahb_q.hwdata <= wd;
      do tick; while (rdy_q !== 1'b1);
      r = rd_q;
   endtask

   task wreg(input logic [7:0] d);
      xfer(1'b1, `CTRL_ADDR, {24'h0, d}, rv);
   endtask

   task creg(input logic [7:0] e);
      xfer(1'b0, `CTRL_ADDR, 32'h0, rv);
      chk(rv, {24'h0, e});
   endtask

   // One array access, result taken one cycle later
   task mem_op(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
      mem_q <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
      tick;
      r = mem_rdata;
      mem_q.valid <= 1'b0;
      tick;
   endtask

   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Test sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      tick;
      creg(8'h00);
      chk(32'(nv_mode), 32'(NV_READ));
      chk(32'(ahb_o.hresp), 32'h0);
      xfer(1'b1, 32'h0000_0020, 32'h0000_00ff, rv);
      xfer(1'b0, 32'h0000_0020, 32'h0, rv);
      chk(rv, 32'h0);
      $display("test reset done");
      wreg(8'h10);
      creg(8'h00);
      wreg(8'h20);
      creg(8'h20);
      chk(32'(blk), 32'h1);
      mem_op(1'b0, 16'h0400, 8'h00, mr);
      chk(32'(mr), 32'h0);
      wreg(8'h30);
      creg(8'h20);
      mem_op(1'b1, 16'h0405, 8'haa, mr);
      mem_op(1'b1, 16'h040f, 8'h55, mr);
      mem_op(1'b1, 16'h0415, 8'h77, mr);
      chk(32'(otp_prog.group), 32'h040);
      chk(32'(otp_prog.mask), 32'h8020);
      chk(32'(otp_prog.data[5]), 32'haa);
      wreg(8'h30);
      creg(8'h30);
      chk(32'(otp_mode), 32'(OTP_PROGRAM));
      wreg(8'h20);
      creg(8'h30);
      wreg(8'h00);
      creg(8'h00);
      chk(32'(otp_prog.active), 32'h0);
      for (int i = 0; i < 6; i++) begin
         mem_op(1'b0, dec_a[i], 8'h00, mr);
         chk(32'(mr), (i > 3) ? 32'h0 : 32'h3c);
      end
      mem_op(1'b1, 16'h0406, 8'h11, mr);
      chk(32'(otp_prog.mask), 32'h0);
      $display("test one-time array done");
      wreg(8'h01);
      creg(8'h00);
      wreg(8'h06);
      creg(8'h02);
      wreg(8'h06);
      creg(8'h06);
      wreg(8'h07);
      creg(8'h06);
      mem_op(1'b1, 16'h0110, 8'h5a, mr);
      chk(32'(nv_prog.data), 32'h5a);
      wreg(8'h03);
      creg(8'h07);
      chk(32'(nv_mode), 32'(NV_ERASE));
      chk(32'(nv_prog.erase), 32'h1);
      chk(32'(nv_prog.pump_on), 32'h1);
      mem_op(1'b1, 16'h0111, 8'h11, mr);
      chk(32'(nv_prog.addr), 32'h0110);
      wreg(8'h02);
      creg(8'h07);
      wreg(8'h00);
      creg(8'h00);
      mem_op(1'b0, 16'h0150, 8'h00, mr);
      chk(32'(mr), 32'h96);
      wreg(8'h02);
      mem_op(1'b1, 16'h0120, 8'hc3, mr);
      wreg(8'h03);
      chk(32'(nv_mode), 32'(NV_PROGRAM));
      $display("test byte array done");
      wreg(8'h22);
      mem_op(1'b1, 16'h0500, 8'h01, mr);
      stop_mode <= 1'b1;
      tick;
      stop_mode <= 1'b0;
      creg(8'h00);
      chk(32'(otp_mode), 32'(OTP_READ));
      chk(32'(nv_prog.pump_on), 32'h0);
      $display("test stop done");
      wreg(8'hc8);
      creg(8'h08);
      chk(32'(clk_oe), 32'h1);
      opt <= 1'b1;
      can_sleep <= 1'b1;
      repeat (4) tick;
      creg(8'h48);
      wreg(8'h80);
      creg(8'hc0);
      chk(32'(irq_en), 32'h1);
      can_sleep <= 1'b0;
      repeat (4) tick;
      chk(32'(asleep), 32'h0);
      rst <= 1'b1;
      tick;
      rst <= 1'b0;
      tick;
      creg(8'h00);
      $display("test flags done");
      stop_test;
   end
endmodule // tb
